// ### hdl/pace_cm_ref_control_regs.sv
// pace detection and common-mode/reference control registers
//
// Decided for this implementation: the address-and-strobe port.
module pace_cm_ref_control_regs (
  input  wire logic        core_clk,                    // 20 MHz clock
  input  wire logic        rst_n,                       // async reset
  input  wire logic [7:0]  reg_addr,                    // register address
  input  wire logic [23:0] reg_wdata,                   // write data
  input  wire logic        reg_wr,                      // write strobe
  input  wire logic        reg_rd,                      // read strobe
  output logic      [23:0] reg_rdata,                   // read data
  output logic             pace_width_filter_enable,    // width filter on
  output logic             pace_validation_filter_b_enable, // filter b on
  output logic             pace_validation_filter_a_enable, // filter a on
  output logic      [1:0]  detector_c_lead_select,      // lead code c
  output logic      [1:0]  detector_b_lead_select,      // lead code b
  output logic      [1:0]  detector_a_lead_select,      // lead code a
  output logic             detector_c_enable,           // detector c on
  output logic             detector_b_enable,           // detector b on
  output logic             detector_a_enable,           // detector a on
  output logic      [4:0]  cm_electrode_switch,         // la,ll,ra,v1,v2
  output logic             cm_single_electrode,         // one electrode
  output logic             internal_common_mode_reference, // ref used
  output logic             external_common_mode_select, // external src
  output logic             common_mode_pin_output_enable, // pin drive
  output logic      [5:0]  drive_sum_switch,            // la..ce to sum
  output logic             common_electrode_reference_enable, // ce ref
  output logic      [5:0]  drive_electrode_onehot,      // out,la..v2
  output logic             right_leg_drive_enable,      // rld ref on
  output logic             shield_driver_enable         // shield on
);

  typedef struct packed {
    logic [23:0] pace;
    logic [23:0] cm;
    logic [23:0] rdata;
    logic [4:0]  cm_sw;
    logic        cm_single;
    logic        cm_ref;
    logic        pin_drv;
    logic [5:0]  drv_1h;
  } state_t;

  state_t s_q;
  state_t s_d;

  cm_decode_if cm_if ();

  cm_mix_decode u_cm_mix (
    .cm (cm_if.dec)
  );

  logic        wr_pace;
  logic        wr_cm;
  logic [3:0]  drv_code;
  logic [23:0] cm_next;

  assign wr_pace = reg_wr && (reg_addr == regs_pkg::PACE_ADDR);
  assign wr_cm   = reg_wr && (reg_addr == regs_pkg::CM_ADDR);

  // next common-mode word, kept apart from the state copy to avoid a loop
  assign cm_next = wr_cm ? (reg_wdata & regs_pkg::CM_MASK) : s_q.cm;

  assign cm_if.sel =
    cm_next[regs_pkg::CM_SEL_LO +: regs_pkg::CM_N];
  assign cm_if.ext     = cm_next[regs_pkg::EXT_CM_BIT];
  assign cm_if.pin_req = cm_next[regs_pkg::PIN_DRV_BIT];

  assign drv_code = cm_next[regs_pkg::DRV_SEL_LO +: 4];

  always_comb begin
    s_d = s_q;
    // reserved bits are dropped so they read back as zero
    if (wr_pace) begin
      s_d.pace = reg_wdata & regs_pkg::PACE_MASK;
    end
    s_d.cm = cm_next;
    // read data from the stored value, before any same-cycle write
    if (reg_rd) begin
      unique case (reg_addr)
        regs_pkg::PACE_ADDR: s_d.rdata = s_q.pace;
        regs_pkg::CM_ADDR:   s_d.rdata = s_q.cm;
        default:             s_d.rdata = 24'h000000;
      endcase
    end else begin
      s_d.rdata = 24'h000000;
    end
    // decoded controls track the new register contents
    s_d.cm_sw     = cm_if.sw;
    s_d.cm_single = cm_if.single;
    s_d.cm_ref    = cm_if.use_ref;
    s_d.pin_drv   = cm_if.pin_drv;
    s_d.drv_1h    = 6'h00;
    // reserved codes select no electrode
    if (drv_code <= regs_pkg::DRV_LAST) begin
      s_d.drv_1h[drv_code[2:0]] = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q.pace      <= regs_pkg::PACE_RST;
      s_q.cm        <= regs_pkg::CM_RST;
      s_q.rdata     <= 24'h000000;
      s_q.cm_sw     <= 5'h1c;
      s_q.cm_single <= 1'b0;
      s_q.cm_ref    <= 1'b0;
      s_q.pin_drv   <= 1'b0;
      s_q.drv_1h    <= 6'h01;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  // pace controls
  assign pace_width_filter_enable =
    s_q.pace[regs_pkg::FILT_W_BIT];
  assign pace_validation_filter_b_enable =
    s_q.pace[regs_pkg::FILT_B_BIT];
  assign pace_validation_filter_a_enable =
    s_q.pace[regs_pkg::FILT_A_BIT];
  assign detector_c_lead_select =
    s_q.pace[regs_pkg::SEL_C_LO +: 2];
  assign detector_b_lead_select =
    s_q.pace[regs_pkg::SEL_B_LO +: 2];
  assign detector_a_lead_select =
    s_q.pace[regs_pkg::SEL_A_LO +: 2];
  assign detector_c_enable = s_q.pace[regs_pkg::DET_C_BIT];
  assign detector_b_enable = s_q.pace[regs_pkg::DET_B_BIT];
  assign detector_a_enable = s_q.pace[regs_pkg::DET_A_BIT];
  // common-mode and reference controls
  assign cm_electrode_switch            = s_q.cm_sw;
  assign cm_single_electrode            = s_q.cm_single;
  assign internal_common_mode_reference = s_q.cm_ref;
  assign external_common_mode_select =
    s_q.cm[regs_pkg::EXT_CM_BIT];
  assign common_mode_pin_output_enable  = s_q.pin_drv;
  // summing switches are never forced open by the drive state
  assign drive_sum_switch =
    s_q.cm[regs_pkg::SUM_LO +: regs_pkg::SUM_N];
  assign common_electrode_reference_enable =
    s_q.cm[regs_pkg::CE_REF_BIT];
  assign drive_electrode_onehot = s_q.drv_1h;
  assign right_leg_drive_enable =
    s_q.cm[regs_pkg::RLD_EN_BIT];
  assign shield_driver_enable =
    s_q.cm[regs_pkg::SHIELD_BIT];

  // checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  chk_pace_write_back: assert property (
    wr_pace ##1 (reg_rd && reg_addr == regs_pkg::PACE_ADDR)
    |=> reg_rdata == ($past(reg_wdata, 2) & regs_pkg::PACE_MASK))
    else $error("pace readback differs from written value");

  chk_cm_write_back: assert property (
    wr_cm ##1 (reg_rd && reg_addr == regs_pkg::CM_ADDR)
    |=> reg_rdata == ($past(reg_wdata, 2) & regs_pkg::CM_MASK))
    else $error("common-mode readback differs from written value");

  chk_rdata_one_cycle: assert property (
    !reg_rd |=> reg_rdata == 24'h000000)
    else $error("read data present without read strobe");

  chk_unmapped_read: assert property (
    (reg_rd && reg_addr != regs_pkg::PACE_ADDR
     && reg_addr != regs_pkg::CM_ADDR) |=> reg_rdata == 24'h000000)
    else $error("unmapped read returned nonzero");

  chk_filter_follow: assert property (
    wr_pace |=> pace_width_filter_enable == $past(reg_wdata[11])
      && pace_validation_filter_b_enable == $past(reg_wdata[10])
      && pace_validation_filter_a_enable == $past(reg_wdata[9]))
    else $error("filter enables not following write");

  chk_detector_follow: assert property (
    wr_pace |=> {detector_c_enable, detector_b_enable,
                 detector_a_enable} == $past(reg_wdata[2:0])
      && detector_c_lead_select == $past(reg_wdata[8:7])
      && detector_b_lead_select == $past(reg_wdata[6:5])
      && detector_a_lead_select == $past(reg_wdata[4:3]))
    else $error("detector controls not following write");

  chk_ext_opens_all: assert property (
    external_common_mode_select |-> cm_electrode_switch == 5'h00
      && !cm_single_electrode && !internal_common_mode_reference)
    else $error("internal switch closed under external mode");

  chk_switch_follow: assert property (
    !external_common_mode_select |->
      cm_electrode_switch == s_q.cm[23:19])
    else $error("electrode switches differ from select bits");

  chk_single_onehot: assert property (
    cm_single_electrode |-> $onehot(cm_electrode_switch))
    else $error("single flag without exactly one electrode");

  chk_ref_when_none: assert property (
    (!external_common_mode_select && s_q.cm[23:19] == 5'h00)
    |-> internal_common_mode_reference)
    else $error("internal reference not used with no electrode");

  chk_pin_drive: assert property (
    common_mode_pin_output_enable == (s_q.cm[3] && !s_q.cm[2]))
    else $error("pin drive disagrees with control bits");

  chk_sum_held: assert property (
    !wr_cm |=> $stable(drive_sum_switch))
    else $error("summing switches changed without a write");

  chk_drive_reserved: assert property (
    (s_q.cm[7:4] > 4'h5) |-> drive_electrode_onehot == 6'h00)
    else $error("reserved drive code selected an electrode");

  chk_drive_onehot: assert property (
    (s_q.cm[7:4] <= 4'h5) |->
      drive_electrode_onehot == (6'h01 << s_q.cm[6:4]))
    else $error("drive electrode decode wrong");

  chk_reserved_zero: assert property (
    s_q.cm[18:15] == 4'h0 && s_q.pace[23:12] == 12'h000)
    else $error("reserved bits hold ones");

  chk_filter_b_follow: assert property (
    wr_pace
    |=> pace_validation_filter_b_enable == $past(reg_wdata[regs_pkg::FILT_B_BIT]))
    else $error("second validation filter not following write");

  chk_filter_a_follow: assert property (
    wr_pace
    |=> pace_validation_filter_a_enable == $past(reg_wdata[regs_pkg::FILT_A_BIT]))
    else $error("first validation filter not following write");

  chk_width_filter_hold: assert property (
    !wr_pace
    |=> $stable(pace_width_filter_enable))
    else $error("width filter enable changed without a write");

  chk_filter_b_hold: assert property (
    !wr_pace
    |=> $stable(pace_validation_filter_b_enable))
    else $error("second validation filter changed without a write");

  chk_filter_a_hold: assert property (
    !wr_pace
    |=> $stable(pace_validation_filter_a_enable))
    else $error("first validation filter changed without a write");

  chk_lead_hold: assert property (
    !wr_pace |=> $stable({detector_c_lead_select,
      detector_b_lead_select, detector_a_lead_select}))
    else $error("lead selects changed without a write");

  chk_detector_hold: assert property (
    !wr_pace
    |=> $stable({detector_c_enable, detector_b_enable, detector_a_enable}))
    else $error("detector enables changed without a write");

  chk_cm_sel_follow: assert property (
    (wr_cm && !reg_wdata[regs_pkg::EXT_CM_BIT])
    |=> cm_electrode_switch == $past(reg_wdata[regs_pkg::CM_SEL_LO +: regs_pkg::CM_N]))
    else $error("electrode switches not following write");

  chk_single_exact: assert property (
    (!external_common_mode_select && $onehot(s_q.cm[regs_pkg::CM_SEL_LO +: regs_pkg::CM_N]))
    |-> cm_single_electrode)
    else $error("single electrode not flagged");

  chk_ext_ignores_sel: assert property (
    (wr_cm && reg_wdata[regs_pkg::EXT_CM_BIT])
    |=> cm_electrode_switch == 5'h00 && !cm_single_electrode)
    else $error("select bits honoured under external mode");

  chk_ref_only_none: assert property (
    internal_common_mode_reference
    |-> cm_electrode_switch == 5'h00 && !external_common_mode_select)
    else $error("internal reference used with electrodes selected");

  chk_sum_follow: assert property (
    wr_cm
    |=> drive_sum_switch == $past(reg_wdata[regs_pkg::SUM_LO +: regs_pkg::SUM_N]))
    else $error("summing switches not following write");

  chk_sum_kept_drive_off: assert property (
    (wr_cm && !reg_wdata[regs_pkg::RLD_EN_BIT])
    |=> drive_sum_switch == $past(reg_wdata[regs_pkg::SUM_LO +: regs_pkg::SUM_N]))
    else $error("summing switches forced with drive disabled");

  chk_ce_ref_follow: assert property (
    wr_cm
    |=> common_electrode_reference_enable == $past(reg_wdata[regs_pkg::CE_REF_BIT]))
    else $error("common electrode reference not following write");

  chk_drive_dedicated: assert property (
    (wr_cm && reg_wdata[regs_pkg::DRV_SEL_LO +: 4] == regs_pkg::DRV_DEDICATED)
    |=> drive_electrode_onehot == 6'h01)
    else $error("dedicated drive output not selected");

  chk_pin_follow: assert property (
    wr_cm
    |=> common_mode_pin_output_enable == ($past(reg_wdata[regs_pkg::PIN_DRV_BIT])
      && !$past(reg_wdata[regs_pkg::EXT_CM_BIT])))
    else $error("pin drive not following write");

  chk_ext_follow: assert property (
    wr_cm
    |=> external_common_mode_select == $past(reg_wdata[regs_pkg::EXT_CM_BIT]))
    else $error("external mode not following write");

  chk_rld_follow: assert property (
    wr_cm
    |=> right_leg_drive_enable == $past(reg_wdata[regs_pkg::RLD_EN_BIT]))
    else $error("right leg drive enable not following write");

  chk_shield_follow: assert property (
    wr_cm
    |=> shield_driver_enable == $past(reg_wdata[regs_pkg::SHIELD_BIT]))
    else $error("shield enable not following write");

  chk_unmapped_write: assert property (
    (reg_wr && reg_addr != regs_pkg::PACE_ADDR && reg_addr != regs_pkg::CM_ADDR)
    |=> $stable(s_q.pace) && $stable(s_q.cm))
    else $error("unmapped write changed a register");

  chk_pace_hold: assert property (
    !wr_pace
    |=> $stable(s_q.pace))
    else $error("pace register changed without a write");

endmodule

// ### hdl/regs_pkg.sv
// constants for the pace and common-mode control register pair
package regs_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 24;
  localparam logic [7:0] PACE_ADDR = 8'h04;
  localparam logic [7:0] CM_ADDR   = 8'h05;
  localparam logic [23:0] PACE_RST  = 24'h000f88;
  localparam logic [23:0] CM_RST    = 24'he00000;
  localparam logic [23:0] PACE_MASK = 24'h000fff;
  localparam logic [23:0] CM_MASK   = 24'hf87fff;
  // pace control fields
  localparam int FILT_W_BIT  = 11;
  localparam int FILT_B_BIT  = 10;
  localparam int FILT_A_BIT  = 9;
  localparam int SEL_C_LO    = 7;
  localparam int SEL_B_LO    = 5;
  localparam int SEL_A_LO    = 3;
  localparam int DET_C_BIT   = 2;
  localparam int DET_B_BIT   = 1;
  localparam int DET_A_BIT   = 0;
  // common-mode control fields
  localparam int CM_SEL_LO   = 19;
  localparam int SUM_LO      = 9;
  localparam int CE_REF_BIT  = 8;
  localparam int DRV_SEL_LO  = 4;
  localparam int PIN_DRV_BIT = 3;
  localparam int EXT_CM_BIT  = 2;
  localparam int RLD_EN_BIT  = 1;
  localparam int SHIELD_BIT  = 0;
  localparam int CM_N  = 5;
  localparam int SUM_N = 6;
  localparam int DRV_N = 6;
  typedef enum logic [1:0] {
    LEAD_I   = 2'b00,
    LEAD_II  = 2'b01,
    LEAD_III = 2'b10,
    LEAD_AVF = 2'b11
  } lead_t;
  // drive electrode codes, 0110..1111 reserved
  localparam logic [3:0] DRV_DEDICATED = 4'h0;
  localparam logic [3:0] DRV_LAST      = 4'h5;
endpackage

// ### hdl/cm_decode_if.sv
// carrier between register block and common-mode decoder
interface cm_decode_if;
  logic [regs_pkg::CM_N-1:0] sel;
  logic                      ext;
  logic                      pin_req;
  logic [regs_pkg::CM_N-1:0] sw;
  logic                      single;
  logic                      use_ref;
  logic                      pin_drv;
  modport regs (output sel, output ext, output pin_req,
                input sw, input single, input use_ref, input pin_drv);
  modport dec (input sel, input ext, input pin_req,
               output sw, output single, output use_ref, output pin_drv);
endinterface

// ### hdl/cm_mix_decode.sv
// common-mode electrode mix decode
module cm_mix_decode (
  cm_decode_if.dec cm  // select bits in, switch controls out
);
  logic [2:0] cnt;

  always_comb begin
    cnt = 3'h0;
    for (int i = 0; i < regs_pkg::CM_N; i++) begin
      cnt = cnt + {2'h0, cm.sel[i]};
    end
    // external source opens every internal switch
    cm.sw      = cm.ext ? '0 : cm.sel;
    cm.single  = !cm.ext && (cnt == 3'h1);
    cm.use_ref = !cm.ext && (cnt == 3'h0);
    cm.pin_drv = cm.pin_req && !cm.ext;
  end
endmodule

// ### tb/testbench.sv
// self-checking bench for the pace and common-mode register pair
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk  = 1'b0;
  logic        rst_n     = 1'b0;
  logic [7:0]  reg_addr  = 8'h00;
  logic [23:0] reg_wdata = 24'h000000;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic [23:0] reg_rdata;
  logic        filt_w, filt_b, filt_a, det_c, det_b, det_a;
  logic [1:0]  sel_c, sel_b, sel_a;
  logic [4:0]  cm_sw;
  logic        cm_one, cm_ref, cm_ext, cm_pin, ce_ref, rld_en, shield;
  logic [5:0]  sum_sw, drv_oh;
  int          n_fail          = 0;
  int          samples_checked = 0;
  int          pace_m          = 'h000f88;
  int          cm_m            = 'he00000;
  logic [7:0]  a;
  logic [23:0] d;
  logic [23:0] exp_q[$];

  always #25 core_clk = ~core_clk;

  pace_cm_ref_control_regs dut_u (
    .core_clk                          (core_clk),
    .rst_n                             (rst_n),
    .reg_addr                          (reg_addr),
    .reg_wdata                         (reg_wdata),
    .reg_wr                            (reg_wr),
    .reg_rd                            (reg_rd),
    .reg_rdata                         (reg_rdata),
    .pace_width_filter_enable          (filt_w),
    .pace_validation_filter_b_enable   (filt_b),
    .pace_validation_filter_a_enable   (filt_a),
    .detector_c_lead_select            (sel_c),
    .detector_b_lead_select            (sel_b),
    .detector_a_lead_select            (sel_a),
    .detector_c_enable                 (det_c),
    .detector_b_enable                 (det_b),
    .detector_a_enable                 (det_a),
    .cm_electrode_switch               (cm_sw),
    .cm_single_electrode               (cm_one),
    .internal_common_mode_reference    (cm_ref),
    .external_common_mode_select       (cm_ext),
    .common_mode_pin_output_enable     (cm_pin),
    .drive_sum_switch                  (sum_sw),
    .common_electrode_reference_enable (ce_ref),
    .drive_electrode_onehot            (drv_oh),
    .right_leg_drive_enable            (rld_en),
    .shield_driver_enable              (shield)
  );

  task check(input logic [23:0] seen, input logic [23:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  // compare every control output with the model
  task outs;
    logic [4:0] sel;
    logic [3:0] code;
    logic       ext;
    ext  = cm_m[2];
    sel  = ext ? 5'h00 : cm_m[23:19];
    code = cm_m[7:4];
    check({21'h0, filt_w, filt_b, filt_a}, pace_m[11:9]);
    check({18'h0, sel_c, sel_b, sel_a}, pace_m[8:3]);
    check({21'h0, det_c, det_b, det_a}, pace_m[2:0]);
    check({19'h0, cm_sw}, {19'h0, sel});
    check({23'h0, cm_one}, {23'h0, $countones(sel) == 1});
    check({23'h0, cm_ref}, {23'h0, sel == 5'h00 && !ext});
    check({23'h0, cm_ext}, {23'h0, ext});
    check({23'h0, cm_pin}, {23'h0, cm_m[3] & ~ext});
    check({18'h0, sum_sw}, cm_m[14:9]);
    check({23'h0, ce_ref}, cm_m[8]);
    check({18'h0, drv_oh}, (code <= 4'h5) ? (24'h1 << code) : 24'h0);
    check({23'h0, rld_en}, cm_m[1]);
    check({23'h0, shield}, cm_m[0]);
  endtask

  function automatic logic [23:0] model_rd(input logic [7:0] ad);
    return (ad == 8'h04) ? pace_m[23:0] : (ad == 8'h05) ? cm_m[23:0] : 24'h0;
  endfunction

  task rd(input logic [7:0] ad);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= ad;
    exp_q.push_back(model_rd(ad));
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, exp_q.pop_front());
    @(posedge core_clk);
    #1 check(reg_rdata, 24'h000000);
  endtask

  // write, then read the same place back to back
  task access(input logic [7:0] ad, input logic [23:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= ad;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    if (ad == 8'h04) pace_m = d & 24'h000fff;
    else if (ad == 8'h05) cm_m = d & 24'hf87fff;
    exp_q.push_back(model_rd(ad));
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, exp_q.pop_front());
    outs();
  endtask

  task reset_and_check;
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (16) @(posedge core_clk);
    rst_n  <= 1'b1;
    pace_m = 'h000f88;
    cm_m   = 'he00000;
    #1 outs();
    rd(8'h04);
    rd(8'h05);
  endtask

  task tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    #1000000;
    n_fail++;
    $display("unexpected at %0t: run did not finish", $time);
    tally_and_finish();
  end

  initial begin
    void'($urandom(59));
    reset_and_check();
    access(8'h04, 24'h000fff);
    access(8'h05, 24'hffffff);
    access(8'h04, 24'h000000);
    for (int i = 0; i < 16; i++) access(8'h05, {16'h0, i[3:0], 4'h0});
    for (int i = 0; i < 128; i++) begin
      access(8'h05, {i[4:0], 15'h0, i[6], i[5], 2'b00});
    end
    // drive disabled must leave summing switches closed
    access(8'h05, 24'h007e02);
    access(8'h05, 24'h007e00);
    reset_and_check();
    repeat (200) begin
      a = 8'($urandom_range(7, 0));
      d = 24'($urandom);
      if (a == 8'h04) d = d & 24'h000fff;
      access(a, d);
      rd(a ^ 8'h01);
    end
    access(8'h9c, 24'h123456);
    tally_and_finish();
  end
endmodule
